// ==== tkw_pkg.sv ====
package tkw_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PRESC_W = 16;
  localparam int CNT_W = 32;
  localparam int TAP_W = 4;
  localparam int DIV_W = 8;
  localparam int SHIFT_W = 4;
  localparam int TUNE_W = 24;
  localparam int CEIL_W = 9;

  // ----------------------------------------------------------------
  // wakeup and event sources
  // ----------------------------------------------------------------
  localparam int SRC_N = 3;
  localparam int SRC_OVF = 0;
  localparam int SRC_ALARM = 1;
  localparam int SRC_PER = 2;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [SRC_N-1:0] SRC_NONE = 3'h0;
  localparam logic [PRESC_W-1:0] PRESC_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [TUNE_W-1:0] TUNE_RST = 24'h00_0000;
  localparam logic [DIV_W-1:0] DIV_OFF = 8'h00;
  localparam logic [CEIL_W:0] TUNE_BASE = 10'h100;
  localparam logic [CEIL_W:0] ONE_10 = 10'h001;
  localparam logic [TUNE_W-1:0] ONE_24 = 24'h00_0001;
  localparam logic [1:0] INC_SKIP = 2'h0;
  localparam logic [1:0] INC_NORM = 2'h1;
  localparam logic [1:0] INC_DBL = 2'h2;
  localparam int CLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic direction;
    logic [SHIFT_W-1:0] shift;
    logic [DIV_W-1:0] divisor;
  } tkw_tune_t;

  typedef struct packed {
    logic [TAP_W-1:0] countTap;
    logic [TAP_W-1:0] periodTap;
  } tkw_tap_t;

endpackage

// ==== tkw_wakeup_tuner.sv ====
`timescale 1ns/1ns
module tkw_wakeup_tuner
  import tkw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration from software
  input wire tkw_tune_t tuneCfg,
  input wire tkw_tap_t tapCfg,
  input wire logic [CNT_W-1:0] alarmValue,
  input wire logic [SRC_N-1:0] wakeEnable,
  // one-cycle write strobes, one bit per source
  input wire logic [SRC_N-1:0] notifyEnableWr,
  input wire logic [SRC_N-1:0] notifyDisableWr,
  input wire logic [SRC_N-1:0] intEnableWr,
  input wire logic [SRC_N-1:0] intDisableWr,
  input wire logic [SRC_N-1:0] statusClearWr,
  // sleep controller
  input wire logic inShutdown,
  output logic cpuWake,
  output logic resumeFromReset,
  // events and state
  output logic [SRC_N-1:0] notifyOut,
  output logic [SRC_N-1:0] notifyMask,
  output logic [SRC_N-1:0] intMask,
  output logic [SRC_N-1:0] statusFlags,
  output logic [CNT_W-1:0] counterValue,
  output logic [PRESC_W-1:0] prescValue
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PRESC_W-1:0] presc_r;
  logic [CNT_W-1:0] counter_r;
  logic [TUNE_W-1:0] tuneCnt_r;
  logic cntTapPrev_r;
  logic perTapPrev_r;
  logic [SRC_N-1:0] notifyMask_r;
  logic [SRC_N-1:0] intMask_r;
  logic [SRC_N-1:0] statusFlags_r;
  logic [SRC_N-1:0] wakePend_r;
  logic [SRC_N-1:0] notifyOut_r;
  logic [CNT_W-1:0] cvReg_r;
  logic resumeFromReset_r;

  logic [PRESC_W-1:0] presc_nxt;
  logic [CNT_W-1:0] counter_nxt;
  logic [CEIL_W-1:0] ceilVal;
  logic [TUNE_W-1:0] tuneLast;
  logic tuneOn;
  logic tuneFire;
  logic [1:0] prescInc;
  logic cntTapNow;
  logic perTapNow;
  logic cntTick;
  logic [SRC_N-1:0] evNow;
  logic wakeAny;
  logic shutdownExit;

  // ----------------------------------------------------------------
  // digital tuner
  // ----------------------------------------------------------------
  function automatic logic [CEIL_W-1:0] ceilDiv(input logic [DIV_W-1:0] d);
    logic [CEIL_W:0] dw;
    logic [CEIL_W:0] q;
    dw = {2'h0, d};
    q = (TUNE_BASE + dw - ONE_10) / dw;
    return q[CEIL_W-1:0];
  endfunction

  // divisor zero would divide by zero, so it is masked first
  assign tuneOn = (tuneCfg.divisor != DIV_OFF);
  assign ceilVal = tuneOn ? ceilDiv(tuneCfg.divisor) : 9'h000;
  // period of ceil*2^shift+1 cycles, one of which is corrected
  assign tuneLast = TUNE_W'({15'h0000, ceilVal} << tuneCfg.shift);
  assign tuneFire = tuneOn && (tuneCnt_r == tuneLast);

  always_comb begin
    prescInc = INC_NORM;
    if (tuneFire && !tuneCfg.direction) begin
      prescInc = INC_SKIP;
    end else if (tuneFire && tuneCfg.direction) begin
      prescInc = INC_DBL;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tuneCnt_r <= TUNE_RST;
    end else if (!tuneOn || tuneFire) begin
      tuneCnt_r <= TUNE_RST;
    end else begin
      tuneCnt_r <= tuneCnt_r + ONE_24;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  assign presc_nxt = presc_r + {14'h0000, prescInc};
  assign cntTapNow = presc_r[tapCfg.countTap];
  assign perTapNow = presc_r[tapCfg.periodTap];
  assign cntTick = cntTapNow && !cntTapPrev_r;
  // wrap from all ones counts as overflow
  assign counter_nxt = cntTick ? counter_r + 32'h0000_0001 : counter_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_r <= PRESC_RST;
      cntTapPrev_r <= 1'b0;
      perTapPrev_r <= 1'b0;
    end else begin
      presc_r <= presc_nxt;
      cntTapPrev_r <= cntTapNow;
      perTapPrev_r <= perTapNow;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter_r <= CNT_RST;
    end else begin
      counter_r <= counter_nxt;
    end
  end

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  always_comb begin
    evNow = SRC_NONE;
    evNow[SRC_OVF] = cntTick && (counter_r == CNT_MAX);
    evNow[SRC_ALARM] = cntTick && (counter_nxt == alarmValue);
    evNow[SRC_PER] = perTapNow && !perTapPrev_r;
  end

  // ----------------------------------------------------------------
  // notify mask and event output
  // ----------------------------------------------------------------
  // set wins if software writes enable and disable together
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      notifyMask_r <= SRC_NONE;
    end else begin
      notifyMask_r <= (notifyMask_r & ~notifyDisableWr) | notifyEnableWr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      notifyOut_r <= SRC_NONE;
    end else begin
      notifyOut_r <= evNow & notifyMask_r;
    end
  end

  // ----------------------------------------------------------------
  // status flags and wake
  // ----------------------------------------------------------------
  // not touched by shutdown, so flags raised there survive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusFlags_r <= SRC_NONE;
    end else begin
      statusFlags_r <= (statusFlags_r & ~statusClearWr) | evNow;
    end
  end

  // wake ignores the interrupt mask entirely
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakePend_r <= SRC_NONE;
    end else begin
      wakePend_r <= (wakePend_r & ~statusClearWr) | (evNow & wakeEnable);
    end
  end

  assign wakeAny = |wakePend_r;
  // a level, so a sleep entered while pending returns at once
  assign cpuWake = wakeAny && !inShutdown;
  assign shutdownExit = inShutdown && wakeAny;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resumeFromReset_r <= 1'b0;
    end else begin
      resumeFromReset_r <= shutdownExit && !resumeFromReset_r;
    end
  end

  // ----------------------------------------------------------------
  // interrupt mask and counter snapshot
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intMask_r <= SRC_NONE;
    end else if (shutdownExit) begin
      intMask_r <= SRC_NONE;
    end else begin
      intMask_r <= (intMask_r & ~intDisableWr) | intEnableWr;
    end
  end

  // snapshot frozen in shutdown, refreshed at the exit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cvReg_r <= CNT_RST;
    end else if (!inShutdown || shutdownExit) begin
      cvReg_r <= counter_nxt;
    end
  end

  assign notifyOut = notifyOut_r;
  assign notifyMask = notifyMask_r;
  assign intMask = intMask_r;
  assign statusFlags = statusFlags_r;
  assign counterValue = cvReg_r;
  assign prescValue = presc_r;
  assign resumeFromReset = resumeFromReset_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_notify_gate: assert property (
    (notifyOut_r & ~$past(notifyMask_r)) == SRC_NONE)
    else $error("event left while masked");
  a_mask_set: assert property (
    (notifyEnableWr != SRC_NONE) |=>
      ((notifyMask_r & $past(notifyEnableWr)) == $past(notifyEnableWr)))
    else $error("notify enable did not set mask");
  a_mask_quiet: assert property (
    (notifyEnableWr == SRC_NONE && notifyDisableWr == SRC_NONE)
      |=> $stable(notifyMask_r))
    else $error("mask changed without write");
  a_ovf_flag: assert property (
    (cntTick && counter_r == CNT_MAX && !statusClearWr[SRC_OVF])
      |=> statusFlags_r[SRC_OVF] && counter_r == CNT_RST)
    else $error("overflow not flagged");
  a_wake_cause: assert property (
    $rose(wakeAny) |-> $past((evNow & wakeEnable) != SRC_NONE))
    else $error("wake without enabled source");
  a_wake_hold: assert property (
    (wakeAny && statusClearWr == SRC_NONE) |=> wakeAny)
    else $error("wake dropped without clear");
  a_sleep_wake: assert property (
    (wakeAny && !inShutdown) |-> cpuWake)
    else $error("pending wake not presented");
  a_shd_mask: assert property (
    shutdownExit |=> intMask_r == SRC_NONE)
    else $error("interrupt mask kept over shutdown");
  a_cv_load: assert property (
    shutdownExit |=> cvReg_r == $past(counter_nxt))
    else $error("counter snapshot not loaded");
  a_status_keep: assert property (
    (statusClearWr == SRC_NONE) |=>
      ((statusFlags_r & $past(statusFlags_r)) == $past(statusFlags_r)))
    else $error("status flag lost");
  a_reset_vec: assert property (
    (shutdownExit && !resumeFromReset_r) |=> resumeFromReset_r ##1
      !resumeFromReset_r)
    else $error("reset vector pulse wrong");
  a_tune_lower: assert property (
    (tuneFire && !tuneCfg.direction) |=> presc_r == $past(presc_r))
    else $error("lowering skip missing");
  // the release edge itself still holds the prescaler in reset
  a_tune_off: assert property (
    (tuneCfg.divisor == DIV_OFF && !sys_rst) |=>
      presc_r == $past(presc_r) + 16'h0001)
    else $error("tuning active with zero divisor");
  a_tune_raise: assert property (
    (tuneFire && tuneCfg.direction) |=> presc_r == $past(presc_r) + 16'h0002)
    else $error("raising step missing");

  c_shutdown_wake: cover property (shutdownExit ##1 resumeFromReset_r);
  c_sleep_wake: cover property ($rose(cpuWake));
  c_notify_out: cover property (notifyOut_r != SRC_NONE);
  c_tune_fire: cover property (tuneFire && tuneCfg.direction);

endmodule

// ==== tkw_sleep_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// sleep controller model
// ----------------------------------------------------------------
module tkw_sleep_model
  import tkw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request from software, answer from the block
  input wire logic shutdownReq,
  input wire logic resumeFromReset,
  // to the block and the bench
  output logic inShutdown,
  output logic [7:0] bootCnt
);
  // shutdown is left only through a cold start, never mid-program
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inShutdown <= 1'b0;
    end else if (resumeFromReset) begin
      inShutdown <= 1'b0;
    end else if (shutdownReq) begin
      inShutdown <= 1'b1;
    end
  end
  // cold starts counted, so a double pulse shows up as an extra boot
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bootCnt <= 8'h00;
    end else if (resumeFromReset) begin
      bootCnt <= bootCnt + 8'h01;
    end
  end
endmodule

// ==== test_tkw_wakeup_tuner.sv ====
`timescale 1ns/1ns
module test_tkw_wakeup_tuner
  import tkw_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk, sys_rst, inShutdown, cpuWake, resumeFromReset, shutdownReq;
  tkw_tune_t tuneCfg;
  tkw_tap_t tapCfg;
  logic [CNT_W-1:0] alarmValue, counterValue, aExp;
  logic [SRC_N-1:0] wakeEnable, notifyEnableWr, notifyDisableWr;
  logic [SRC_N-1:0] intEnableWr, intDisableWr, statusClearWr;
  logic [SRC_N-1:0] notifyOut, notifyMask, intMask, statusFlags;
  logic [PRESC_W-1:0] prescValue;
  logic [7:0] bootCnt;
  int error_cnt, checked, wakeCyc, i;
  int evCnt[3];

  tkw_wakeup_tuner uut (.clk(clk), .sys_rst(sys_rst), .tuneCfg(tuneCfg),
    .tapCfg(tapCfg), .alarmValue(alarmValue), .wakeEnable(wakeEnable),
    .notifyEnableWr(notifyEnableWr), .notifyDisableWr(notifyDisableWr),
    .intEnableWr(intEnableWr), .intDisableWr(intDisableWr),
    .statusClearWr(statusClearWr), .inShutdown(inShutdown),
    .cpuWake(cpuWake), .resumeFromReset(resumeFromReset),
    .notifyOut(notifyOut), .notifyMask(notifyMask), .intMask(intMask),
    .statusFlags(statusFlags), .counterValue(counterValue),
    .prescValue(prescValue));

  tkw_sleep_model partner (.clk(clk), .sys_rst(sys_rst),
    .shutdownReq(shutdownReq), .resumeFromReset(resumeFromReset),
    .inShutdown(inShutdown), .bootCnt(bootCnt));

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle strobe: 0 notify set, 1 notify clear, 2 int set,
  // 3 int clear, else status clear
  task automatic wr(input int k, input logic [2:0] b);
    @(posedge clk);
    case (k)
      0: notifyEnableWr <= b;
      1: notifyDisableWr <= b;
      2: intEnableWr <= b;
      3: intDisableWr <= b;
      default: statusClearWr <= b;
    endcase
    @(posedge clk);
    {notifyEnableWr, notifyDisableWr, intEnableWr} <= 9'h000;
    {intDisableWr, statusClearWr} <= 6'h00;
    #1;
  endtask

  task automatic watch(input int n);
    evCnt = '{0, 0, 0};
    wakeCyc = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      for (int s = 0; s < 3; s++) evCnt[s] += int'(notifyOut[s]);
      wakeCyc += int'(cpuWake);
    end
  endtask

  // prescaler advance over a whole number of tuning periods
  task automatic tune(input logic [7:0] d, input logic [3:0] sh,
                      input logic dir);
    int n;
    int w;
    int e;
    logic [15:0] p0;
    n = (d == 8'h00) ? 0 : ((255 + int'(d)) / int'(d)) << sh;
    w = (n + 1) * 4;
    e = w + ((d == 8'h00) ? 0 : (dir ? 4 : -4));
    @(posedge clk);
    tuneCfg <= '{direction: dir, shift: sh, divisor: d};
    repeat (10) @(posedge clk);
    #1;
    p0 = prescValue;
    repeat (w) @(posedge clk);
    #1;
    check({16'h0000, prescValue - p0}, {16'h0000, 16'(e)});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    tuneCfg = '{direction: 1'b0, shift: 4'h1, divisor: 8'h00};
    tapCfg = '{countTap: 4'h0, periodTap: 4'h0};
    alarmValue = 32'h0000_0000;
    wakeEnable = 3'h0;
    {notifyEnableWr, notifyDisableWr, intEnableWr} = 9'h000;
    {intDisableWr, statusClearWr} = 6'h00;
    shutdownReq = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    wr(0, 3'h7);
    check(notifyMask, 3'h7);
    wr(1, 3'h2);
    check(notifyMask, 3'h5);
    wr(0, 3'h0);
    wr(1, 3'h0);
    check(notifyMask, 3'h5);
    watch(20);
    check(evCnt[2], 10);
    check(evCnt[0] + evCnt[1], 0);
    wr(1, 3'h4);
    watch(20);
    check(evCnt[2], 0);
    check(statusFlags[2], 1'b1);
    check(wakeCyc, 0);
    @(posedge clk);
    wakeEnable <= 3'h4;
    watch(10);
    check(cpuWake, 1'b1);
    @(posedge clk);
    wakeEnable <= 3'h0;
    watch(10);
    check(wakeCyc, 10);
    check(bootCnt, 8'h00);
    wr(4, 3'h4);
    check(cpuWake, 1'b0);
    // alarm then periodic, each as the only wake source in shutdown
    for (int s = 1; s < 3; s++) begin
      wr(0, 3'h2);
      wr(2, 3'h7);
      wr(4, 3'h7);
      // snapshot read while settled, not at the launching edge
      aExp = counterValue + 32'h0000_0010;
      @(posedge clk);
      alarmValue <= aExp;
      wakeEnable <= 3'(1 << s);
      shutdownReq <= 1'b1;
      @(posedge clk);
      shutdownReq <= 1'b0;
      for (i = 0; i < 80; i++) begin
        @(posedge clk);
        #1;
        if (resumeFromReset === 1'b1) break;
      end
      if (i == 80) begin
        check(32'h0, 32'h1);
        print_verdict();
      end
      // boot count and snapshot settle one edge after the pulse
      @(posedge clk);
      #1;
      check(bootCnt, 8'(s));
      check(intMask, 3'h0);
      check(notifyMask, 3'h3);
      check(statusFlags[s], 1'b1);
      if (s == 1) check(counterValue - aExp < 2, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      check(cpuWake, 1'b1);
      wr(2, 3'h2);
      check(intMask, 3'h2);
      @(posedge clk);
      wakeEnable <= 3'h0;
    end
    wr(4, 3'h7);
    tune(8'h00, 4'h1, 1'b0);
    tune(8'h80, 4'h1, 1'b0);
    tune(8'h80, 4'h1, 1'b1);
    tune(8'h55, 4'h2, 1'b0);
    print_verdict();
  end
endmodule
